// [rtl/fts_defines.svh]
// Constants for the flag test and skip logic
`ifndef FTS_DEFINES_SVH
`define FTS_DEFINES_SVH

// Instruction word width and codes
`define FTS_INSTR_W        10
`define FTS_OP_EXT0        10'h038
`define FTS_OP_CONV        10'h287
`define FTS_OP_PIN         10'h03A

// Bus widths
`define FTS_ADDR_W         8
`define FTS_DATA_W         32
`define FTS_NIB_W          4

// Register byte offsets
`define FTS_OFF_CTRL1      8'h00
`define FTS_OFF_CTRL2      8'h04
`define FTS_OFF_EXTCTRL    8'h08
`define FTS_OFF_STATUS     8'h0C
`define FTS_OFF_MASK       8'h10
`define FTS_OFF_STATE      8'h14

// Field positions
`define FTS_EXT0_EN_BIT    0
`define FTS_CONV_EN_BIT    2
`define FTS_POL_BIT        2
`define FTS_ST_EXT0_BIT    0
`define FTS_ST_CONV_BIT    1
`define FTS_ST_SKIP_BIT    2
`define FTS_SKIPPEND_BIT   0
`define FTS_ST_W           3

// Reset values
`define FTS_RST_NIB        4'h0
`define FTS_RST_ST         3'h0

// Bus responses
`define FTS_RESP_OKAY      2'h0
`define FTS_RESP_SLVERR    2'h2

`endif

// [rtl/fts_pkg.sv]
// Types shared by the flag test and skip logic
package fts_pkg;

   // Decoded test instruction
   typedef enum logic [1:0]
   {
      FTS_OP_NONE = 2'b00,
      FTS_OP_EXT0 = 2'b01,
      FTS_OP_CONV = 2'b10,
      FTS_OP_PIN  = 2'b11
   } fts_op_t;

   // Register selected by a bus address
   typedef enum logic [2:0]
   {
      FTS_R_CTRL1   = 3'b000,
      FTS_R_CTRL2   = 3'b001,
      FTS_R_EXTCTRL = 3'b010,
      FTS_R_STATUS  = 3'b011,
      FTS_R_MASK    = 3'b100,
      FTS_R_STATE   = 3'b101,
      FTS_R_NONE    = 3'b111
   } fts_reg_t;

endpackage

// [rtl/fts_flag_test_skip.sv]
// Skip logic for flag and interrupt pin test instructions
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "fts_defines.svh"

module fts_flag_test_skip
(
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   input  wire logic                       ce,
   input  wire logic                       instr_valid,
   input  wire logic [`FTS_INSTR_W-1:0]    instr_code,
   input  wire logic                       irq_pin,
   input  wire logic                       ext0_event,
   input  wire logic                       conv_event,
   output logic                            instr_squash,
   output logic                            skip_next_reg,
   output logic                            op_is_test_reg,
   output logic                            irq,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [`FTS_ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   input  wire logic [`FTS_DATA_W-1:0]     s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   output logic [1:0]                      s_axi_bresp,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   input  wire logic [`FTS_ADDR_W-1:0]     s_axi_araddr,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   output logic [`FTS_DATA_W-1:0]          s_axi_rdata,
   output logic [1:0]                      s_axi_rresp
);
   import fts_pkg::*;

   // Map a byte address onto a register
   function automatic fts_reg_t addr_sel(input logic [`FTS_ADDR_W-1:0] addr);
      case (addr)
         `FTS_OFF_CTRL1:   addr_sel = FTS_R_CTRL1;
         `FTS_OFF_CTRL2:   addr_sel = FTS_R_CTRL2;
         `FTS_OFF_EXTCTRL: addr_sel = FTS_R_EXTCTRL;
         `FTS_OFF_STATUS:  addr_sel = FTS_R_STATUS;
         `FTS_OFF_MASK:    addr_sel = FTS_R_MASK;
         `FTS_OFF_STATE:   addr_sel = FTS_R_STATE;
         default:          addr_sel = FTS_R_NONE;
      endcase
   endfunction

   // Map an instruction word onto a test kind
   function automatic fts_op_t op_decode(input logic [`FTS_INSTR_W-1:0] code);
      case (code)
         `FTS_OP_EXT0: op_decode = FTS_OP_EXT0;
         `FTS_OP_CONV: op_decode = FTS_OP_CONV;
         `FTS_OP_PIN:  op_decode = FTS_OP_PIN;
         default:      op_decode = FTS_OP_NONE;
      endcase
   endfunction

   // Control registers written by software
   logic [`FTS_NIB_W-1:0]   irq_control_first_reg;  // Holds ext0 enable
   logic [`FTS_NIB_W-1:0]   irq_control_second_reg; // Holds conv enable
   logic [`FTS_NIB_W-1:0]   ext_irq_control_reg;    // Holds pin polarity
   logic [`FTS_ST_W-1:0]    mask_reg;               // Interrupt mask

   // Flags and skip state
   logic                    ext0_request_flag_reg;  // Ext0 request
   logic                    ext0_request_flag_next;
   logic                    conv_done_flag_reg;     // Conversion done
   logic                    conv_done_flag_next;
   logic                    skip_seen_reg;          // A skip happened
   logic                    skip_seen_next;
   logic                    skip_pending_next;

   // Named enable and polarity bits
   logic                    ext0_irq_enable;
   logic                    conv_irq_enable;
   logic                    pin_polarity_select;

   // Current instruction decode
   fts_op_t                 op;
   logic                    exec;        // Instruction really executes
   logic                    take_skip;   // Test holds, skip next
   logic                    clr_ext0;    // Skip clears ext0 flag
   logic                    clr_conv;    // Skip clears conv flag

   // Bus write side
   logic                    aw_held_reg; // Address captured
   logic [`FTS_ADDR_W-1:0]  aw_addr_reg;
   logic                    w_held_reg;  // Data captured
   logic [`FTS_DATA_W-1:0]  w_data_reg;
   logic [3:0]              w_strb_reg;
   logic                    wr_fire;     // Both halves present
   fts_reg_t                wr_sel;
   logic                    wr_lane0;    // Low byte lane enabled
   logic [`FTS_ST_W-1:0]    w1c;         // Status bits to clear
   logic [`FTS_ST_W-1:0]    status;

   // Bus read side
   fts_reg_t                rd_sel;
   logic [`FTS_DATA_W-1:0]  rd_word;

   // Enable and polarity bits taken from their registers
   assign ext0_irq_enable     = irq_control_first_reg[`FTS_EXT0_EN_BIT];
   assign conv_irq_enable     = irq_control_second_reg[`FTS_CONV_EN_BIT];
   assign pin_polarity_select = ext_irq_control_reg[`FTS_POL_BIT];

   // Status view of the flags
   assign status = {skip_seen_reg, conv_done_flag_reg, ext0_request_flag_reg};

   // A skipped word is fetched but squashed here
   assign instr_squash = instr_valid & skip_next_reg;

   // Only an unsquashed word on an enabled cycle acts
   assign exec = ce & instr_valid & ~skip_next_reg;
   assign op   = op_decode(instr_code);

   // Decide whether the current test holds
   always_comb
   begin
      take_skip = 1'b0;
      clr_ext0  = 1'b0;
      clr_conv  = 1'b0;
      if (exec)
      begin
         case (op)
            FTS_OP_EXT0:
               // Enable set turns the test into a no-operation
               if (!ext0_irq_enable && ext0_request_flag_reg)
               begin
                  take_skip = 1'b1;
                  clr_ext0  = 1'b1;
               end
            FTS_OP_CONV:
               // Same shape as the ext0 test
               if (!conv_irq_enable && conv_done_flag_reg)
               begin
                  take_skip = 1'b1;
                  clr_conv  = 1'b1;
               end
            // Skip when the pin matches the chosen level
            FTS_OP_PIN:  take_skip = (irq_pin == pin_polarity_select);
            default:     take_skip = 1'b0;
         endcase
      end
   end

   // Software write clear of status bits
   assign wr_sel   = addr_sel(aw_addr_reg);
   assign wr_fire  = aw_held_reg & w_held_reg & ~s_axi_bvalid;
   assign wr_lane0 = w_strb_reg[0];
   assign w1c      = (wr_fire && wr_lane0 && wr_sel == FTS_R_STATUS) ?
                     w_data_reg[`FTS_ST_W-1:0] : `FTS_RST_ST;

   // Next flag values, a new event beats any clear
   always_comb
   begin
      ext0_request_flag_next = ext0_request_flag_reg;
      conv_done_flag_next    = conv_done_flag_reg;
      skip_seen_next         = skip_seen_reg;
      if (clr_ext0 || w1c[`FTS_ST_EXT0_BIT])
         ext0_request_flag_next = 1'b0;
      if (clr_conv || w1c[`FTS_ST_CONV_BIT])
         conv_done_flag_next = 1'b0;
      if (w1c[`FTS_ST_SKIP_BIT])
         skip_seen_next = 1'b0;
      if (ext0_event)
         ext0_request_flag_next = 1'b1;
      if (conv_event)
         conv_done_flag_next = 1'b1;
      if (take_skip)
         skip_seen_next = 1'b1;
   end

   // Skip state: a squashed word ends the pending skip
   always_comb
   begin
      skip_pending_next = skip_next_reg;
      if (ce && instr_valid)
         skip_pending_next = take_skip;
   end

   // Flag registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ext0_request_flag_reg <= 1'b0;
         conv_done_flag_reg    <= 1'b0;
         skip_seen_reg         <= 1'b0;
      end
      else if (ce)
      begin
         ext0_request_flag_reg <= ext0_request_flag_next;
         conv_done_flag_reg    <= conv_done_flag_next;
         skip_seen_reg         <= skip_seen_next;
      end
   end

   // Skip request towards the core and test marker
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         skip_next_reg  <= 1'b0;
         op_is_test_reg <= 1'b0;
      end
      else if (ce)
      begin
         skip_next_reg  <= skip_pending_next;
         op_is_test_reg <= exec && (op != FTS_OP_NONE);
      end
   end

   // Interrupt output from unmasked status bits
   assign irq = |(status & mask_reg);

   // Write address capture
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= '0;
      end
      else if (ce)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         else if (wr_fire)
            aw_held_reg <= 1'b0;
      end
   end

   // Write data capture
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_reg <= 1'b0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
      end
      else if (ce)
      begin
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         else if (wr_fire)
            w_held_reg <= 1'b0;
      end
   end

   // Each half is accepted once until the response is taken
   assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;

   // Write response, error for an unmapped address
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `FTS_RESP_OKAY;
      end
      else if (ce)
      begin
         if (wr_fire)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_sel == FTS_R_NONE) ? `FTS_RESP_SLVERR : `FTS_RESP_OKAY;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Control register writes, low lane only
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_control_first_reg  <= `FTS_RST_NIB;
         irq_control_second_reg <= `FTS_RST_NIB;
         ext_irq_control_reg    <= `FTS_RST_NIB;
         mask_reg               <= `FTS_RST_ST;
      end
      else if (ce && wr_fire && wr_lane0)
      begin
         case (wr_sel)
            FTS_R_CTRL1:   irq_control_first_reg  <= w_data_reg[`FTS_NIB_W-1:0];
            FTS_R_CTRL2:   irq_control_second_reg <= w_data_reg[`FTS_NIB_W-1:0];
            FTS_R_EXTCTRL: ext_irq_control_reg    <= w_data_reg[`FTS_NIB_W-1:0];
            FTS_R_MASK:    mask_reg               <= w_data_reg[`FTS_ST_W-1:0];
            default:       ; // Status is handled by the clear path
         endcase
      end
   end

   // Read multiplexer
   assign rd_sel = addr_sel(s_axi_araddr);
   always_comb
   begin
      rd_word = '0;
      case (rd_sel)
         FTS_R_CTRL1:   rd_word[`FTS_NIB_W-1:0] = irq_control_first_reg;
         FTS_R_CTRL2:   rd_word[`FTS_NIB_W-1:0] = irq_control_second_reg;
         FTS_R_EXTCTRL: rd_word[`FTS_NIB_W-1:0] = ext_irq_control_reg;
         FTS_R_STATUS:  rd_word[`FTS_ST_W-1:0]  = status;
         FTS_R_MASK:    rd_word[`FTS_ST_W-1:0]  = mask_reg;
         FTS_R_STATE:   rd_word[`FTS_SKIPPEND_BIT] = skip_next_reg;
         default:       rd_word = '0;
      endcase
   end

   // One read at a time
   assign s_axi_arready = ~s_axi_rvalid;

   // Read data and response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= `FTS_RESP_OKAY;
      end
      else if (ce)
      begin
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= (rd_sel == FTS_R_NONE) ? `FTS_RESP_SLVERR : `FTS_RESP_OKAY;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// [verification/fts_flag_test_skip_sva.sv]
// Assertion checker for the flag test and skip logic
`timescale 1ns/1ps
`default_nettype none
`include "fts_defines.svh"
module fts_flag_test_skip_sva
(
   input wire logic                    aclk,
   input wire logic                    aresetn,
   input wire logic                    ce,
   input wire logic                    instr_valid,
   input wire logic [`FTS_INSTR_W-1:0] instr_code,
   input wire logic                    instr_squash,
   input wire logic                    skip_next_reg,
   input wire logic                    op_is_test_reg,
   input wire logic                    irq,
   input wire logic                    s_axi_arvalid,
   input wire logic                    s_axi_arready,
   input wire logic                    s_axi_rvalid,
   input wire logic                    s_axi_rready,
   input wire logic [`FTS_DATA_W-1:0]  s_axi_rdata,
   input wire logic                    s_axi_bvalid,
   input wire logic                    s_axi_bready
);
   logic plain_w;  // Word is none of the three test codes

   // Classify the presented word
   assign plain_w = (instr_code != `FTS_OP_EXT0) && (instr_code != `FTS_OP_CONV) && (instr_code != `FTS_OP_PIN);

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   squash_follows_a: assert property (instr_squash == (instr_valid && skip_next_reg))
      else $error("squash does not match pending skip");
   squash_clears_a: assert property (ce && instr_valid && skip_next_reg |=> !skip_next_reg)
      else $error("squashed word left a skip pending");
   plain_no_skip_a: assert property (ce && instr_valid && !skip_next_reg && plain_w |=> !skip_next_reg)
      else $error("ordinary word caused a skip");
   skip_stands_a: assert property (ce && !instr_valid && skip_next_reg |=> skip_next_reg)
      else $error("pending skip dropped without a word");
   ce_freeze_a: assert property (!ce |=> $stable(skip_next_reg) && $stable(s_axi_rvalid))
      else $error("state moved while clock enable low");
   rd_answer_a: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   rd_stands_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   wr_stands_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response not held");
   ar_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer pending");
   test_marked_a: assert property (ce && instr_valid && !skip_next_reg && !plain_w |=> op_is_test_reg)
      else $error("executed test word not marked");
   marker_idle_a: assert property (ce && (!instr_valid || skip_next_reg || plain_w) |=> !op_is_test_reg)
      else $error("test marker without an executed test word");

   // Main scenarios seen
   cover property (instr_squash);
   cover property (irq);
   cover property (s_axi_rvalid && !s_axi_rready);
endmodule
`default_nettype wire

// [verification/test_flag_test_skip_logic.sv]
// Self-checking bench for the flag test and skip logic
`timescale 1ns/1ps
`default_nettype none
`include "fts_defines.svh"
module test_flag_test_skip_logic;
   logic        aclk, aresetn, ce, instr_valid, irq_pin, ext0_event, conv_event;  // Core side
   logic [9:0]  instr_code;                                                        // Presented word
   logic        instr_squash, skip_next_reg, op_is_test_reg, irq;                  // Results
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;         // Write request
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;         // Response and read
   logic        s_axi_rvalid, s_axi_rready;                                        // Read answer
   logic [7:0]  s_axi_awaddr, s_axi_araddr;                                        // Addresses
   logic [31:0] s_axi_wdata, s_axi_rdata, lfsr_reg;                                // Data and random state
   logic [3:0]  s_axi_wstrb;                                                       // Always full word
   logic [1:0]  s_axi_bresp, s_axi_rresp;                                          // Responses
   logic [33:0] qr[$];                                                             // Expected reads
   logic [1:0]  qb[$];                                                             // Expected write codes
   int          mismatches, checks, cycles;                                        // Counters

   fts_flag_test_skip u_dut (.*);

   // Clock at 100 MHz
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // Next random state
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Count and report one comparison
   task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Verdict and end of run
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Bus write; response ready raised only once the answer shows, to exercise holding
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      qb.push_back(er);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      // Handshake edge checked first so ready is driven once per time step
      forever
      begin
         @(posedge aclk);
         if (s_axi_bvalid && s_axi_bready) break;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) s_axi_bready <= 1'b1;
      end
      s_axi_bready <= 1'b0;
   endtask

   // Bus read; expectation noted for the monitor
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      qr.push_back({er, e});
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      // Handshake edge checked first so ready is driven once per time step
      forever
      begin
         @(posedge aclk);
         if (s_axi_rvalid && s_axi_rready) break;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) s_axi_rready <= 1'b1;
      end
      s_axi_rready <= 1'b0;
   endtask

   // Present one word for one edge; caller lowers valid with idl
   task automatic ins(input logic [9:0] c);
      instr_valid <= 1'b1;
      instr_code  <= c;
      @(posedge aclk);
   endtask

   task automatic idl;
      instr_valid <= 1'b0;
      @(posedge aclk);
   endtask

   // Pulse the flag events for one cycle
   task automatic ev(input logic e0, input logic ec);
      ext0_event <= e0;
      conv_event <= ec;
      @(posedge aclk);
      ext0_event <= 1'b0;
      conv_event <= 1'b0;
   endtask

   // Sample the interrupt level once settled
   task automatic ckirq(input logic e);
      @(posedge aclk);
      #1;
      chk("irq", {33'h0, irq}, {33'h0, e});
      @(posedge aclk);
   endtask

   // One test word under given controls, flags and pin; checks skip, flags and readback
   task automatic run(input logic [3:0] c0, c2, c8, input logic e0, ec, pin, input logic [9:0] code,
                      input logic sk, input logic [2:0] st);
      irq_pin  <= pin;
      lfsr_reg = lfsr(lfsr_reg);
      wr(`FTS_OFF_CTRL1, {lfsr_reg[31:4], c0}, `FTS_RESP_OKAY);
      wr(`FTS_OFF_CTRL2, {lfsr_reg[27:0], c2}, `FTS_RESP_OKAY);
      wr(`FTS_OFF_EXTCTRL, {lfsr_reg[31:4], c8}, `FTS_RESP_OKAY);
      rd(`FTS_OFF_CTRL1, {28'h0, c0}, `FTS_RESP_OKAY);
      rd(`FTS_OFF_CTRL2, {28'h0, c2}, `FTS_RESP_OKAY);
      rd(`FTS_OFF_EXTCTRL, {28'h0, c8}, `FTS_RESP_OKAY);
      ev(e0, ec);
      ins(code);
      idl;
      rd(`FTS_OFF_STATE, {31'h0, sk}, `FTS_RESP_OKAY);
      rd(`FTS_OFF_STATUS, {29'h0, st}, `FTS_RESP_OKAY);
      lfsr_reg = lfsr(lfsr_reg);
      ins({2'b01, lfsr_reg[7:0]});
      idl;
      rd(`FTS_OFF_STATE, 32'h0, `FTS_RESP_OKAY);
      wr(`FTS_OFF_STATUS, 32'h7, `FTS_RESP_OKAY);
   endtask

   // Monitor: compare each answer with the oldest note
   always @(posedge aclk)
   begin
      if (s_axi_rvalid && s_axi_rready)
         chk("read", {s_axi_rresp, s_axi_rdata}, qr.pop_front());
      if (s_axi_bvalid && s_axi_bready)
         chk("bresp", {32'h0, s_axi_bresp}, {32'h0, qb.pop_front()});
   end

   // Cut a hang short
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         mismatches++;
         finish_test;
      end
   end

   // Main sequence
   initial
   begin
      {aresetn, instr_valid, irq_pin, ext0_event, conv_event, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready, instr_code, s_axi_awaddr, s_axi_araddr} = '0;
      ce = 1'b1;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      lfsr_reg = 32'h869FC3A8;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values, unmapped place last
      for (int i = 0; i < 7; i++)
         rd(8'(i * 4), 32'h0, (i == 6) ? `FTS_RESP_SLVERR : `FTS_RESP_OKAY);
      wr(8'h18, 32'h1, `FTS_RESP_SLVERR);
      run(4'h0, 4'h0, 4'h0, 1'b1, 1'b0, 1'b0, `FTS_OP_EXT0, 1'b1, 3'h4);
      run(4'h0, 4'h0, 4'h0, 1'b0, 1'b0, 1'b0, `FTS_OP_EXT0, 1'b0, 3'h0);
      run(4'h1, 4'h0, 4'h0, 1'b1, 1'b0, 1'b0, `FTS_OP_EXT0, 1'b0, 3'h1);
      run(4'h0, 4'h0, 4'h0, 1'b0, 1'b1, 1'b0, `FTS_OP_CONV, 1'b1, 3'h4);
      run(4'h0, 4'h4, 4'h0, 1'b0, 1'b1, 1'b0, `FTS_OP_CONV, 1'b0, 3'h2);
      run(4'hE, 4'hB, 4'h0, 1'b0, 1'b1, 1'b0, `FTS_OP_CONV, 1'b1, 3'h4);
      run(4'h0, 4'h0, 4'h0, 1'b0, 1'b0, 1'b0, `FTS_OP_PIN, 1'b1, 3'h4);
      run(4'h0, 4'h0, 4'h0, 1'b0, 1'b0, 1'b1, `FTS_OP_PIN, 1'b0, 3'h0);
      run(4'h0, 4'h0, 4'h4, 1'b0, 1'b0, 1'b1, `FTS_OP_PIN, 1'b1, 3'h4);
      run(4'h0, 4'h0, 4'h4, 1'b1, 1'b1, 1'b0, `FTS_OP_PIN, 1'b0, 3'h3);
      run(4'h0, 4'h0, 4'h3, 1'b1, 1'b0, 1'b0, `FTS_OP_PIN, 1'b1, 3'h5);
      // Test word right behind a skip is squashed and leaves its flag alone
      ev(1'b1, 1'b1);
      ins(`FTS_OP_EXT0);
      ins(`FTS_OP_CONV);
      idl;
      rd(`FTS_OFF_STATUS, 32'h6, `FTS_RESP_OKAY);
      rd(`FTS_OFF_STATE, 32'h0, `FTS_RESP_OKAY);
      wr(`FTS_OFF_STATUS, 32'h7, `FTS_RESP_OKAY);
      // Pending skip survives words offered while the clock enable is low
      ev(1'b1, 1'b0);
      ins(`FTS_OP_EXT0);
      ce <= 1'b0;
      ins(10'h155);
      ins(10'h1AA);
      ce <= 1'b1;
      idl;
      rd(`FTS_OFF_STATE, 32'h1, `FTS_RESP_OKAY);
      ins(10'h100);
      idl;
      wr(`FTS_OFF_STATUS, 32'h7, `FTS_RESP_OKAY);
      // Interrupt raised, masked, unmasked and cleared
      wr(`FTS_OFF_MASK, 32'hFFFF_FFF9, `FTS_RESP_OKAY);
      rd(`FTS_OFF_MASK, 32'h1, `FTS_RESP_OKAY);
      ev(1'b1, 1'b0);
      ckirq(1'b1);
      wr(`FTS_OFF_MASK, 32'h2, `FTS_RESP_OKAY);
      ckirq(1'b0);
      wr(`FTS_OFF_MASK, 32'h1, `FTS_RESP_OKAY);
      ckirq(1'b1);
      wr(`FTS_OFF_STATUS, 32'h1, `FTS_RESP_OKAY);
      ckirq(1'b0);
      repeat (3) @(posedge aclk);
      finish_test;
   end
endmodule

bind fts_flag_test_skip fts_flag_test_skip_sva u_sva (.*);
`default_nettype wire
